// ---- two_wire_slave_defines.svh ----
// register indices, field positions, command codes and reset values for the two-wire slave
// Functional notes
// - byte done flag set on completed byte
// - writing one clears byte done flag
// - data access or valid command clears it
// - match or halt flag on address/stop
// - match flag cleared like byte done
// - set flag stretches SCL, shown read-only
// - keep last master acknowledge bit
// - conflict sets flag, stop driving SDA low
// - collision still completes byte and flags
// - conflict cleared by one or start
// - misplaced start/stop sets protocol fault
// - fault detection needs master unit enabled
// - direction bit from last address byte
// - cause bit: stop zero, address one
// - own id upper bits, bit0 general call
// - data port is shifter, writes blocked while busy
// - data access while stretched starts operation
// - mask bits force address bit match
// - second match select: two addresses
// - stop sets flag only when enabled
// - match all select accepts every address
// - response choice: zero ACK, one NACK
// - command strobes read zero, 2/3 codes
`ifndef TWO_WIRE_SLAVE_DEFINES_SVH
`define TWO_WIRE_SLAVE_DEFINES_SVH

`define IDX_MASTER_CTRL   6'h03
`define IDX_CTRL_A        6'h09
`define IDX_CTRL_B        6'h0A
`define IDX_FLAGS         6'h0B
`define IDX_OWN_ID        6'h0C
`define IDX_SHIFT         6'h0D
`define IDX_MASK          6'h0E

`define FLG_BYTE_DONE     7
`define FLG_MATCH_HALT    6
`define FLG_CONFLICT      3
`define FLG_FAULT         2

`define CA_ENABLE         0
`define CA_MATCH_ALL      2
`define CA_HALT_EN        5
`define CA_WR_MASK        8'hE7
`define CB_RESPONSE       2

`define CMD_COMPLETE      2'h2
`define CMD_RESPOND       2'h3
`define GENERAL_CALL      7'h00
`define REG_RESET         8'h00

`endif

// ---- two_wire_slave_pkg.sv ----
// types shared by the two-wire slave
package two_wire_slave_pkg;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_WAIT = 7'h04,
    ST_ACK  = 7'h08,
    ST_RX   = 7'h10,
    ST_TX   = 7'h20,
    ST_MACK = 7'h40
  } phase_t;

  typedef enum logic [1:0] {
    WK_ADDR = 2'h0,
    WK_RX   = 2'h1,
    WK_TX   = 2'h2
  } wait_kind_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

endpackage

// ---- two_wire_slave.sv ----
// two-wire slave: status flags, address match, data shifter and APB registers
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_slave_defines.svh"

module two_wire_slave
  import two_wire_slave_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // apb slave
  input  wire apb_req_t    apb_req,
  output var  logic        pready,
  output var  logic [31:0] prdata,
  output var  logic        pslverr,
  // bus lines, open drain
  input  wire logic        scl_in,
  output var  logic        scl_out,
  output var  logic        scl_oe,
  input  wire logic        sda_in,
  output var  logic        sda_out,
  output var  logic        sda_oe
);

  // ---------------- synchronisers ----------------
  logic scl_s1_reg, scl_s2_reg, scl_d_reg;
  logic sda_s1_reg, sda_s2_reg, sda_d_reg;

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_d_reg  <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_d_reg  <= 1'b1;
    end
    else
    begin
      scl_s1_reg <= scl_in;
      scl_s2_reg <= scl_s1_reg;
      scl_d_reg  <= scl_s2_reg;
      sda_s1_reg <= sda_in;
      sda_s2_reg <= sda_s1_reg;
      sda_d_reg  <= sda_s2_reg;
    end
  end

  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise  = scl_s2_reg & ~scl_d_reg;
  assign scl_fall  = ~scl_s2_reg & scl_d_reg;
  assign start_det = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
  assign stop_det  = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;

  // ---------------- registers ----------------
  logic [7:0] ctrl_a_reg;
  logic       response_choice_reg;
  logic       master_en_reg;
  logic [7:0] own_station_id_reg;
  logic [7:0] second_match_mask_reg;
  logic [7:0] shift_reg;
  logic       byte_done_reg, match_halt_reg, conflict_reg, fault_reg;
  logic       dir_reg, cause_reg, last_resp_reg, ack_bit_reg, pready_reg;
  logic       addressed_reg;
  logic [3:0] cnt_reg;
  phase_t     state_reg, ack_next_reg;
  wait_kind_t wk_reg;

  // ---------------- apb decode ----------------
  logic       acc, wr, rd, busy, wr_flags, wr_b, cmd_valid, data_wr, data_rd;
  logic       sw_clear, go, done, hold_req, slave_en;
  logic [5:0] idx;
  logic [1:0] cmd;

  assign acc       = apb_req.psel & apb_req.penable & pready_reg;
  assign idx       = apb_req.paddr[7:2];
  assign wr        = acc & apb_req.pwrite;
  assign rd        = acc & ~apb_req.pwrite;
  assign cmd       = apb_req.pwdata[1:0];
  assign wr_flags  = wr & (idx == `IDX_FLAGS);
  assign wr_b      = wr & (idx == `IDX_CTRL_B);
  // codes 2 and 3 are the valid commands
  assign cmd_valid = wr_b & cmd[1];
  assign busy      = (state_reg == ST_ADDR) | (state_reg == ST_RX) | (state_reg == ST_TX)
                   | (state_reg == ST_ACK) | (state_reg == ST_MACK);
  assign data_wr   = wr & (idx == `IDX_SHIFT);
  assign data_rd   = rd & (idx == `IDX_SHIFT);
  // flag clears on data access or command
  assign sw_clear  = data_wr | data_rd | cmd_valid;
  // access while stretched starts next step
  assign go        = (state_reg == ST_WAIT) & (data_wr | data_rd | (wr_b & cmd == `CMD_RESPOND));
  assign done      = (state_reg == ST_WAIT) & wr_b & (cmd == `CMD_COMPLETE);
  assign hold_req  = (state_reg == ST_WAIT) & (byte_done_reg | (match_halt_reg & cause_reg));
  assign slave_en  = ctrl_a_reg[`CA_ENABLE];

  function automatic logic addr_hit(input logic [6:0] a, input logic [7:0] own,
                                    input logic [7:0] msk, input logic all);
    logic gc;
    gc = own[0] & (a == `GENERAL_CALL);
    if (all)
      addr_hit = 1'b1;
    else if (msk[0])
      addr_hit = gc | (a == own[7:1]) | (a == msk[7:1]);
    else
      addr_hit = gc | (((a ^ own[7:1]) & ~msk[7:1]) == 7'h00);
  endfunction

  // ---------------- configuration registers ----------------
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      ctrl_a_reg            <= `REG_RESET;
      response_choice_reg   <= 1'b0;
      master_en_reg         <= 1'b0;
      own_station_id_reg    <= `REG_RESET;
      second_match_mask_reg <= `REG_RESET;
    end
    else if (wr)
    begin
      case (idx)
        `IDX_CTRL_A:      ctrl_a_reg <= apb_req.pwdata[7:0] & `CA_WR_MASK;
        // response choice is a plain bit
        `IDX_CTRL_B:      response_choice_reg <= apb_req.pwdata[`CB_RESPONSE];
        `IDX_MASTER_CTRL: master_en_reg <= apb_req.pwdata[0];
        `IDX_OWN_ID:      own_station_id_reg <= apb_req.pwdata[7:0];
        `IDX_MASK:        second_match_mask_reg <= apb_req.pwdata[7:0];
        default:          ;
      endcase
    end
  end

  // ---------------- protocol engine and flags ----------------
  logic [7:0] rx_byte;
  logic       mid_byte;
  assign rx_byte  = {shift_reg[6:0], sda_s2_reg};
  assign mid_byte = (cnt_reg != 4'h0)
                  & ((state_reg == ST_ADDR) | (state_reg == ST_RX) | (state_reg == ST_TX));

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      state_reg      <= ST_IDLE;
      ack_next_reg   <= ST_IDLE;
      wk_reg         <= WK_ADDR;
      cnt_reg        <= 4'h0;
      shift_reg      <= `REG_RESET;
      byte_done_reg  <= 1'b0;
      match_halt_reg <= 1'b0;
      conflict_reg   <= 1'b0;
      fault_reg      <= 1'b0;
      dir_reg        <= 1'b0;
      cause_reg      <= 1'b0;
      last_resp_reg  <= 1'b0;
      ack_bit_reg    <= 1'b0;
      addressed_reg  <= 1'b0;
    end
    else
    begin
      // clears come first so a same-cycle set wins
      // write one clears byte done
      if ((wr_flags & apb_req.pwdata[`FLG_BYTE_DONE]) | sw_clear)
        byte_done_reg <= 1'b0;
      if ((wr_flags & apb_req.pwdata[`FLG_MATCH_HALT]) | sw_clear)
        match_halt_reg <= 1'b0;
      if (wr_flags & apb_req.pwdata[`FLG_CONFLICT])
        conflict_reg <= 1'b0;
      if (wr_flags & apb_req.pwdata[`FLG_FAULT])
        fault_reg <= 1'b0;
      if (data_wr & ~busy)
        shift_reg <= apb_req.pwdata[7:0];

      case (state_reg)
        ST_ADDR:
        begin
          if (scl_rise)
          begin
            shift_reg <= rx_byte;
            cnt_reg   <= cnt_reg + 4'h1;
            if (cnt_reg == 4'h7)
            begin
              if (addr_hit(rx_byte[7:1], own_station_id_reg, second_match_mask_reg,
                           ctrl_a_reg[`CA_MATCH_ALL]))
              begin
                dir_reg        <= rx_byte[0];
                match_halt_reg <= 1'b1;
                cause_reg      <= 1'b1;
                addressed_reg  <= 1'b1;
                wk_reg         <= WK_ADDR;
                state_reg      <= ST_WAIT;
              end
              else
                state_reg <= ST_IDLE;
            end
          end
        end
        ST_WAIT:
        begin
          cnt_reg <= 4'h0;
          if (go)
          begin
            if (wk_reg == WK_TX)
              // a master NACK ends the read
              state_reg <= last_resp_reg ? ST_IDLE : ST_TX;
            else
            begin
              ack_bit_reg  <= response_choice_reg;
              state_reg    <= ST_ACK;
              if (response_choice_reg)
                ack_next_reg <= ST_IDLE;
              else if ((wk_reg == WK_ADDR) & dir_reg)
                ack_next_reg <= ST_TX;
              else
                ack_next_reg <= ST_RX;
            end
          end
          else if (done)
          begin
            // completion: acknowledge a write, then wait for start; a read goes straight to idle
            if (~dir_reg & (wk_reg != WK_TX))
            begin
              ack_bit_reg  <= response_choice_reg;
              ack_next_reg <= ST_IDLE;
              state_reg    <= ST_ACK;
            end
            else
              state_reg <= ST_IDLE;
          end
        end
        ST_ACK:
        begin
          if (scl_rise & ack_bit_reg & ~sda_s2_reg)
            conflict_reg <= 1'b1;
          if (scl_fall)
          begin
            state_reg <= ack_next_reg;
            cnt_reg   <= 4'h0;
          end
        end
        ST_RX:
        begin
          if (scl_rise)
          begin
            shift_reg <= rx_byte;
            cnt_reg   <= cnt_reg + 4'h1;
            if (cnt_reg == 4'h7)
            begin
              byte_done_reg <= 1'b1;
              wk_reg        <= WK_RX;
              state_reg     <= ST_WAIT;
            end
          end
        end
        ST_TX:
        begin
          if (scl_rise)
          begin
            if (shift_reg[7] & ~sda_s2_reg)
              conflict_reg <= 1'b1;
            cnt_reg <= cnt_reg + 4'h1;
          end
          if (scl_fall)
          begin
            shift_reg <= {shift_reg[6:0], 1'b1};
            if (cnt_reg == 4'h8)
              state_reg <= ST_MACK;
          end
        end
        ST_MACK:
        begin
          if (scl_rise)
          begin
            last_resp_reg <= sda_s2_reg;
            // byte sent, even after a conflict
            byte_done_reg <= 1'b1;
            wk_reg        <= WK_TX;
            state_reg     <= ST_WAIT;
          end
        end
        ST_IDLE:  ;
        default:  state_reg <= ST_IDLE;
      endcase

      // misplaced start or stop, master unit on
      if (master_en_reg & (((start_det | stop_det) & mid_byte)
                           | (stop_det & (state_reg == ST_ADDR) & (cnt_reg == 4'h0))))
        fault_reg <= 1'b1;
      if (start_det & slave_en)
      begin
        state_reg    <= ST_ADDR;
        cnt_reg      <= 4'h0;
        conflict_reg <= 1'b0;
        addressed_reg <= 1'b0;
      end
      if (stop_det)
      begin
        state_reg <= ST_IDLE;
        addressed_reg <= 1'b0;
        // stop flag only when enabled
        // keyed to being addressed, not phase: a NACKed byte leaves the phase idle
        if (slave_en & ctrl_a_reg[`CA_HALT_EN] & addressed_reg)
        begin
          match_halt_reg <= 1'b1;
          cause_reg      <= 1'b0;
        end
      end
    end
  end

  // ---------------- line drivers ----------------
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      scl_oe  <= 1'b0;
      sda_oe  <= 1'b0;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end
    else
    begin
      // hold SCL low once the master drops it
      scl_oe  <= hold_req & (scl_oe | ~scl_s2_reg);
      // no low drive after a conflict
      sda_oe  <= ~conflict_reg & (((state_reg == ST_ACK) & ~ack_bit_reg)
                                | ((state_reg == ST_TX) & ~shift_reg[7]));
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end
  end

  // ---------------- apb answer ----------------
  logic [7:0] rd_byte;
  logic       mapped;

  always_comb
  begin
    rd_byte = 8'h00;
    mapped  = 1'b1;
    case (idx)
      `IDX_MASTER_CTRL: rd_byte = {7'h00, master_en_reg};
      `IDX_CTRL_A:      rd_byte = ctrl_a_reg;
      `IDX_CTRL_B:      rd_byte = {5'h00, response_choice_reg, 2'h0};
      `IDX_FLAGS:       rd_byte = {byte_done_reg, match_halt_reg, scl_oe, last_resp_reg,
                                   conflict_reg, fault_reg, dir_reg, cause_reg};
      `IDX_OWN_ID:      rd_byte = own_station_id_reg;
      `IDX_SHIFT:       rd_byte = shift_reg;
      `IDX_MASK:        rd_byte = second_match_mask_reg;
      default:          mapped  = 1'b0;
    endcase
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      pready_reg <= 1'b0;
      pslverr    <= 1'b0;
      prdata     <= 32'h0000_0000;
    end
    else
    begin
      pready_reg <= apb_req.psel & apb_req.penable & ~pready_reg;
      pslverr    <= apb_req.psel & apb_req.penable & ~pready_reg & ~mapped;
      prdata     <= {24'h00_0000, rd_byte};
    end
  end

  assign pready = pready_reg;

endmodule // two_wire_slave

`default_nettype wire

// ---- two_wire_slave_asserts.sv ----
// port checker for the two-wire slave
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_slave_defines.svh"
module two_wire_slave_asserts
  import two_wire_slave_pkg::*;
(
  // clock and reset
  input wire logic        core_clk,
  input wire logic        resetn,
  // apb
  input wire apb_req_t    apb_req,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // bus lines
  input wire logic        scl_in,
  input wire logic        scl_out,
  input wire logic        scl_oe,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  logic       rd;
  logic [5:0] idx;
  assign rd = pready && !apb_req.pwrite;
  assign idx = apb_req.paddr[7:2];
  ready_time_a:
    assert property (apb_req.psel && !apb_req.penable |=> !pready ##1 pready)
    else $error("ready not two cycles after setup");
  ready_pulse_a:
    assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  refuse_index_a:
    assert property (pready |-> pslverr == !(idx inside
      {`IDX_MASTER_CTRL, [`IDX_CTRL_A:`IDX_MASK]}))
    else $error("error flag does not follow the index");
  upper_zero_a:
    assert property (rd |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  strobe_zero_a:
    assert property (rd && idx == `IDX_CTRL_B |-> prdata[1:0] == 2'h0)
    else $error("command bits read back");
  stretch_low_a:
    assert property ($rose(scl_oe) |-> !$past(scl_in))
    else $error("stretch began while SCL high");
  sda_quiet_a:
    assert property (!$stable(sda_oe) |-> !scl_in)
    else $error("SDA moved while SCL high");
  reset_quiet_a:
    assert property ($rose(resetn) |-> !pready && !scl_oe && !sda_oe)
    else $error("outputs active after reset");
  drive_low_a:
    assert property (!scl_out && !sda_out)
    else $error("line driver data not low");
  cover property ($rose(scl_oe));
  cover property (pslverr);
  cover property ($rose(sda_oe));
endmodule // two_wire_slave_asserts

bind two_wire_slave two_wire_slave_asserts chk (
  .core_clk(core_clk), .resetn(resetn), .apb_req(apb_req), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .scl_in(scl_in), .scl_out(scl_out),
  .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));
`default_nettype wire

// ---- two_wire_master_model.sv ----
// behavioural two-wire bus master working through pull-down enables
`timescale 1ns/1ps
`default_nettype none
module two_wire_master_model (
  // timing reference
  input  wire logic clk,
  // line levels
  input  wire logic scl,
  input  wire logic sda,
  // pull-down enables
  output var  logic scl_pull,
  output var  logic sda_pull
);
  int stuck = 0;
  initial
  begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end
  // five clocks a phase gives an 80 ns bit; the slave needs four per phase
  task automatic half();
    repeat (5) @(posedge clk);
  endtask
  // data moves three clocks before SCL is released
  task automatic lead();
    repeat (3) @(posedge clk);
  endtask
  // release SCL and wait while the slave stretches it
  task automatic up();
    int n;
    n = 0;
    scl_pull <= 1'b0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (!scl && n < 3000);
    if (!scl)
    begin
      stuck++;
      $display("CHECK FAILED at %0t: SCL held low too long", $time);
    end
    repeat (4) @(posedge clk);
  endtask
  // two clocks of low before the next data change
  task automatic pulse(output logic v);
    up();
    v = sda;
    scl_pull <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  task automatic start();
    sda_pull <= 1'b1;
    half();
    scl_pull <= 1'b1;
    half();
  endtask
  task automatic stop();
    sda_pull <= 1'b1;
    half();
    up();
    sda_pull <= 1'b0;
    half();
  endtask
  task automatic send_byte(input logic [7:0] b);
    logic v;
    for (int i = 7; i >= 0; i--)
    begin
      sda_pull <= !b[i];
      lead();
      pulse(v);
    end
  endtask
  // releasing SDA both reads the slave's answer and sends a NACK
  task automatic ack(output logic a);
    sda_pull <= 1'b0;
    lead();
    pulse(a);
  endtask
  // holds SDA low through the slave's bits to force a drive conflict
  task automatic jam_byte();
    logic v;
    sda_pull <= 1'b1;
    repeat (8)
    begin
      lead();
      pulse(v);
    end
  endtask
endmodule // two_wire_master_model
`default_nettype wire

// ---- two_wire_slave_test.sv ----
// self-checking bench for the two-wire slave against a behavioural master
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_slave_defines.svh"
module two_wire_slave_test
  import two_wire_slave_pkg::*;
;
  logic        core_clk;
  logic        resetn;
  apb_req_t    apb_req;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        scl_oe;
  logic        sda_oe;
  logic        m_scl;
  logic        m_sda;
  wire logic   scl_line;
  wire logic   sda_line;
  logic [7:0]  rd;
  logic        err;
  logic        v;
  int          bad_count = 0;
  int          n_compared = 0;
  // own id, mask, control A, address byte, expected hit
  logic [7:0]  t_own [5] = '{8'hA5, 8'hA4, 8'hF2, 8'hA4, 8'hA4};
  logic [7:0]  t_msk [5] = '{8'h00, 8'h02, 8'h00, 8'h00, 8'h00};
  logic [7:0]  t_ctl [5] = '{8'h21, 8'h21, 8'h21, 8'h25, 8'h21};
  logic [7:0]  t_byt [5] = '{8'h00, 8'hA6, 8'hF2, 8'h7E, 8'hA6};
  logic        t_hit [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  // open-drain lines with pull-ups
  assign scl_line = !(scl_oe || m_scl);
  assign sda_line = !(sda_oe || m_sda);
  two_wire_slave dut (
    .core_clk(core_clk), .resetn(resetn), .apb_req(apb_req), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .scl_in(scl_line), .scl_out(),
    .scl_oe(scl_oe), .sda_in(sda_line), .sda_out(), .sda_oe(sda_oe));
  two_wire_master_model m (
    .clk(core_clk), .scl(scl_line), .sda(sda_line), .scl_pull(m_scl), .sda_pull(m_sda));
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    bad_count += m.stuck;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // one transfer; an idle cycle follows so psel never toggles within a step
  task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    apb_req <= '{1'b1, 1'b0, w, {idx, 2'h0}, {24'h0, d}};
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (!pready && n < 20);
    rd = prdata[7:0];
    err = pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge core_clk);
    if (n == 20)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: no pready", $time);
      conclude();
    end
  endtask
  task automatic poll(input logic [7:0] mask);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, `IDX_FLAGS, 8'h00);
      n++;
    end
    while ((rd & mask) !== mask && n < 50);
    if ((rd & mask) !== mask)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: flags %h never showed %h", $time, rd, mask);
      conclude();
    end
  endtask
  initial
  begin
    resetn = 1'b0;
    apb_req = '0;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    for (int i = 11; i < 15; i++)
    begin
      apb(1'b0, 6'(i), 8'h00);
      check(rd, `REG_RESET);
    end
    apb(1'b0, 6'h3F, 8'h00);
    check({rd[6:0], err}, 8'h01);
    apb(1'b1, `IDX_MASTER_CTRL, 8'h01);
    apb(1'b1, `IDX_CTRL_A, 8'h21);
    apb(1'b1, `IDX_OWN_ID, 8'hA4);
    // write transfer: address acked, data byte refused
    m.start();
    m.send_byte(8'hA4);
    poll(8'h60);
    check(rd, 8'h61);
    apb(1'b0, `IDX_SHIFT, 8'h00);
    m.ack(v);
    check({7'h0, v}, 8'h00);
    apb(1'b1, `IDX_CTRL_B, 8'h04);
    // a write while receiving must not reach the shifter
    apb(1'b1, `IDX_SHIFT, 8'h55);
    apb(1'b0, `IDX_SHIFT, 8'h00);
    check(rd, 8'hA4);
    m.send_byte(8'h3C);
    poll(8'hA0);
    apb(1'b0, `IDX_SHIFT, 8'h00);
    check(rd, 8'h3C);
    apb(1'b0, `IDX_FLAGS, 8'h00);
    check(rd & 8'hE0, 8'h00);
    m.ack(v);
    check({7'h0, v}, 8'h01);
    apb(1'b1, `IDX_CTRL_B, 8'h00);
    m.stop();
    poll(8'h40);
    check(rd & 8'h41, 8'h40);
    apb(1'b1, `IDX_FLAGS, 8'h40);
    apb(1'b0, `IDX_FLAGS, 8'h00);
    check(rd & 8'h40, 8'h00);
    // read transfer at the second address with a forced drive conflict
    apb(1'b1, `IDX_MASK, 8'h23);
    m.start();
    m.send_byte(8'h23);
    poll(8'h60);
    check(rd & 8'h03, 8'h03);
    apb(1'b1, `IDX_SHIFT, 8'hFF);
    m.ack(v);
    check({7'h0, v}, 8'h00);
    m.jam_byte();
    m.ack(v);
    poll(8'h80);
    check(rd & 8'h98, 8'h98);
    apb(1'b1, `IDX_FLAGS, 8'h08);
    apb(1'b0, `IDX_FLAGS, 8'h00);
    check(rd & 8'h88, 8'h80);
    apb(1'b1, `IDX_CTRL_B, 8'h02);
    apb(1'b0, `IDX_CTRL_B, 8'h00);
    check(rd, 8'h00);
    apb(1'b0, `IDX_FLAGS, 8'h00);
    check(rd & 8'h80, 8'h00);
    m.stop();
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b1, `IDX_FLAGS, 8'hFF);
      apb(1'b1, `IDX_OWN_ID, t_own[i]);
      apb(1'b1, `IDX_MASK, t_msk[i]);
      apb(1'b1, `IDX_CTRL_A, t_ctl[i]);
      m.start();
      m.send_byte(t_byt[i]);
      apb(1'b0, `IDX_FLAGS, 8'h00);
      check(rd & 8'h40, {1'b0, t_hit[i], 6'h00});
      apb(1'b1, `IDX_CTRL_B, 8'h02);
      m.ack(v);
      check({7'h0, v}, {7'h0, !t_hit[i]});
      m.stop();
    end
    for (int e = 1; e >= 0; e--)
    begin
      apb(1'b1, `IDX_MASTER_CTRL, 8'(e));
      m.start();
      m.stop();
      apb(1'b0, `IDX_FLAGS, 8'h00);
      check(rd & 8'h04, 8'(e << 2));
      apb(1'b1, `IDX_FLAGS, 8'hFF);
    end
    conclude();
  end
endmodule // two_wire_slave_test
`default_nettype wire
